// ==== rtl/dog_timer.v ====
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dog_timer_consts.vh"

module dog_timer (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_reset,
  // oscillator and system events
  input  wire        i_internal_rc_oscillator,
  input  wire        i_chip_reset,
  input  wire        i_software_reset_event,
  input  wire        i_low_voltage_reset_event,
  input  wire        i_power_on_reset_event,
  input  wire        i_irq_vector_entered,
  // axi4-lite write address
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [11:0] i_s_axi_awaddr,
  input  wire [2:0]  i_s_axi_awprot,
  // axi4-lite write data
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  // axi4-lite write response
  output reg         o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  output reg  [1:0]  o_s_axi_bresp,
  // axi4-lite read address
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  input  wire [11:0] i_s_axi_araddr,
  input  wire [2:0]  i_s_axi_arprot,
  // axi4-lite read data
  output reg         o_s_axi_rvalid,
  input  wire        i_s_axi_rready,
  output reg  [31:0] o_s_axi_rdata,
  output reg  [1:0]  o_s_axi_rresp,
  // watchdog outputs
  output reg         o_chip_reset_req,
  output wire        o_dog_interval_irq,
  output wire        o_stop_wakeup
);

  // timed access sequence states
  localparam [1:0] KEY_IDLE  = 2'd0;
  localparam [1:0] KEY_FIRST = 2'd1;
  localparam [1:0] KEY_SECND = 2'd2;
  localparam [1:0] KEY_OPEN  = 2'd3;

  function [15:0] reset_div_len;
    input [3:0] sel;
    begin
      reset_div_len = 16'h0001 << sel;
    end
  endfunction

  function [15:0] interval_div_len;
    input [3:0] sel;
    begin
      interval_div_len = `INTERVAL_STEP_TICKS * ({12'h000, sel} + 16'h0001);
    end
  endfunction

  function reg_index_ok;
    input [11:0] addr;
    begin
      reg_index_ok = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00) &&
                     ((addr[9:2] == `IDX_RESET_CAUSE_STATUS) ||
                      (addr[9:2] == `IDX_WATCHDOG_RESET_CONTROL) ||
                      (addr[9:2] == `IDX_WATCHDOG_REFRESH_KEY) ||
                      (addr[9:2] == `IDX_TIMED_ACCESS_KEY) ||
                      (addr[9:2] == `IDX_WATCHDOG_INTERVAL_CONTROL) ||
                      (addr[9:2] == `IDX_IRQ_REQUEST_SECOND) ||
                      (addr[9:2] == `IDX_IRQ_ENABLE_THIRD));
    end
  endfunction

  // control and status state
  reg        dog_reset_enable_reg;
  reg  [3:0] reset_divider_select_reg;
  reg        interval_enable_reg;
  reg  [3:0] interval_divider_select_reg;
  reg        dog_reset_cause_flag_reg;
  reg        software_reset_cause_flag_reg;
  reg        low_voltage_reset_cause_flag_reg;
  reg        power_on_reset_cause_flag_reg;
  reg        dog_interval_irq_flag_reg;
  reg        dog_interval_irq_enable_reg;
  reg  [1:0] key_state_reg;
  reg  [1:0] key_state_next;
  reg        refresh_reg;
  reg        osc_q_reg;

  // bus state
  reg        aw_got_reg;
  reg [11:0] aw_addr_reg;
  reg        w_got_reg;
  reg [31:0] w_data_reg;
  reg  [3:0] w_strb_reg;

  wire       osc_tick;
  wire       reset_wrap;
  wire       interval_wrap;
  wire       do_write;
  wire [7:0] wr_idx;
  wire [7:0] wr_byte;
  wire       wr_lane;
  wire       wr_ok;
  wire       dog_overflow;
  wire       ctrl_write_open;
  wire       wr_reset_ctrl;
  wire       wr_interval_ctrl;

  // oscillator input is already on core clock; rising edge gives one tick
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      osc_q_reg <= 1'b0;
    end else begin
      osc_q_reg <= i_internal_rc_oscillator;
    end
  end

  assign osc_tick = i_internal_rc_oscillator && !osc_q_reg;

  // nothing here looks at a sleep signal, so counting goes on in sleep
  dog_tick_counter u_reset_counter (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_run      (dog_reset_enable_reg),
    .i_clear    (refresh_reg),
    .i_osc_tick (osc_tick),
    .i_div_len  (reset_div_len(reset_divider_select_reg)),
    .o_count    (),
    .o_wrap     (reset_wrap)
  );

  dog_tick_counter u_interval_counter (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_run      (interval_enable_reg),
    .i_clear    (refresh_reg),
    .i_osc_tick (osc_tick),
    .i_div_len  (interval_div_len(interval_divider_select_reg)),
    .o_count    (),
    .o_wrap     (interval_wrap)
  );

  assign dog_overflow = reset_wrap && dog_reset_enable_reg;

  // write channel: address and data accepted in either order
  assign o_s_axi_awready = !aw_got_reg && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_got_reg && !o_s_axi_bvalid;
  assign do_write        = aw_got_reg && w_got_reg && !o_s_axi_bvalid;
  assign wr_idx          = aw_addr_reg[9:2];
  assign wr_byte         = w_data_reg[7:0];
  assign wr_lane         = do_write && w_strb_reg[0];
  assign wr_ok           = reg_index_ok(aw_addr_reg);

  assign ctrl_write_open  = (key_state_reg == KEY_OPEN);
  assign wr_reset_ctrl    = wr_lane && wr_ok && ctrl_write_open &&
                            (wr_idx == `IDX_WATCHDOG_RESET_CONTROL);
  assign wr_interval_ctrl = wr_lane && wr_ok && ctrl_write_open &&
                            (wr_idx == `IDX_WATCHDOG_INTERVAL_CONTROL);

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      aw_got_reg     <= 1'b0;
      aw_addr_reg    <= 12'h000;
      w_got_reg      <= 1'b0;
      w_data_reg     <= 32'h0000_0000;
      w_strb_reg     <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_reg     <= 1'b0;
        w_got_reg      <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // timed access: any other byte restarts; a guarded write closes it again
  always @* begin
    key_state_next = key_state_reg;
    if (wr_lane && wr_ok && (wr_idx == `IDX_TIMED_ACCESS_KEY)) begin
      case (key_state_reg)
        KEY_FIRST: key_state_next = (wr_byte == `KEY_ACCESS_SECOND) ? KEY_SECND :
                                    (wr_byte == `KEY_ACCESS_FIRST) ? KEY_FIRST : KEY_IDLE;
        KEY_SECND: key_state_next = (wr_byte == `KEY_ACCESS_THIRD) ? KEY_OPEN :
                                    (wr_byte == `KEY_ACCESS_FIRST) ? KEY_FIRST : KEY_IDLE;
        default:   key_state_next = (wr_byte == `KEY_ACCESS_FIRST) ? KEY_FIRST : KEY_IDLE;
      endcase
    end else if (wr_reset_ctrl || wr_interval_ctrl) begin
      key_state_next = KEY_IDLE;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset || i_chip_reset || dog_overflow) begin
      key_state_reg <= KEY_IDLE;
    end else begin
      key_state_reg <= key_state_next;
    end
  end

  // refresh pulse: one cycle after a key write, clears both counters
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      refresh_reg <= 1'b0;
    end else begin
      refresh_reg <= wr_lane && wr_ok && (wr_idx == `IDX_WATCHDOG_REFRESH_KEY) &&
                     ((wr_byte == `KEY_REFRESH_A) || (wr_byte == `KEY_REFRESH_B));
    end
  end

  // control registers; a watchdog or other chip reset returns them to defaults
  always @(posedge i_core_clk) begin
    if (i_reset || i_chip_reset || dog_overflow) begin
      dog_reset_enable_reg        <= 1'b0;
      reset_divider_select_reg    <= `RST_RESET_DIVIDER_SELECT;
      interval_enable_reg         <= 1'b0;
      interval_divider_select_reg <= `RST_INTERVAL_DIVIDER_SELECT;
    end else begin
      if (wr_reset_ctrl) begin
        // enable only ever sets; a zero written later is ignored
        dog_reset_enable_reg     <= dog_reset_enable_reg | wr_byte[`BIT_CTRL_ENABLE];
        reset_divider_select_reg <= wr_byte[3:0];
      end
      if (wr_interval_ctrl) begin
        interval_enable_reg         <= wr_byte[`BIT_CTRL_ENABLE];
        interval_divider_select_reg <= wr_byte[3:0];
      end
    end
  end

  // reset cause flags: the hardware set always beats a software clear
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      dog_reset_cause_flag_reg         <= 1'b0;
      software_reset_cause_flag_reg    <= 1'b0;
      low_voltage_reset_cause_flag_reg <= 1'b0;
      power_on_reset_cause_flag_reg    <= 1'b0;
    end else begin
      if (wr_lane && wr_ok && (wr_idx == `IDX_RESET_CAUSE_STATUS)) begin
        dog_reset_cause_flag_reg         <= wr_byte[`BIT_CAUSE_DOG];
        software_reset_cause_flag_reg    <= wr_byte[`BIT_CAUSE_SOFTWARE];
        low_voltage_reset_cause_flag_reg <= wr_byte[`BIT_CAUSE_LOW_VOLTAGE];
        power_on_reset_cause_flag_reg    <= wr_byte[`BIT_CAUSE_POWER_ON];
      end
      if (dog_overflow) begin
        dog_reset_cause_flag_reg <= 1'b1;
      end
      if (i_software_reset_event) begin
        software_reset_cause_flag_reg <= 1'b1;
      end
      if (i_low_voltage_reset_event) begin
        low_voltage_reset_cause_flag_reg <= 1'b1;
      end
      if (i_power_on_reset_event) begin
        power_on_reset_cause_flag_reg <= 1'b1;
      end
    end
  end

  // reset request is registered on the same edge that sets the flag, so both appear together
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_chip_reset_req <= 1'b0;
    end else begin
      o_chip_reset_req <= dog_overflow;
    end
  end

  // interval irq flag and its enable
  always @(posedge i_core_clk) begin
    if (i_reset || i_chip_reset || dog_overflow) begin
      dog_interval_irq_flag_reg   <= 1'b0;
      dog_interval_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_lane && wr_ok && (wr_idx == `IDX_IRQ_ENABLE_THIRD)) begin
        dog_interval_irq_enable_reg <= wr_byte[`BIT_DOG_INTERVAL_IRQ];
      end
      if (i_irq_vector_entered) begin
        dog_interval_irq_flag_reg <= 1'b0;
      end else if (wr_lane && wr_ok && (wr_idx == `IDX_IRQ_REQUEST_SECOND)) begin
        dog_interval_irq_flag_reg <= wr_byte[`BIT_DOG_INTERVAL_IRQ];
      end
      if (interval_wrap) begin
        dog_interval_irq_flag_reg <= 1'b1;
      end
    end
  end

  assign o_dog_interval_irq = dog_interval_irq_flag_reg && dog_interval_irq_enable_reg;
  // wakeup needs no core clock activity beyond the flag and its enable
  assign o_stop_wakeup      = o_dog_interval_irq;

  // read channel: one-cycle registered answer
  assign o_s_axi_arready = !o_s_axi_rvalid;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= reg_index_ok(i_s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      o_s_axi_rdata  <= 32'h0000_0000;
      if (reg_index_ok(i_s_axi_araddr)) begin
        case (i_s_axi_araddr[9:2])
          `IDX_RESET_CAUSE_STATUS:
            o_s_axi_rdata[3:0] <= {dog_reset_cause_flag_reg, software_reset_cause_flag_reg,
                                   low_voltage_reset_cause_flag_reg,
                                   power_on_reset_cause_flag_reg};
          `IDX_WATCHDOG_RESET_CONTROL:
            o_s_axi_rdata[5:0] <= {dog_reset_enable_reg, 1'b0, reset_divider_select_reg};
          `IDX_WATCHDOG_INTERVAL_CONTROL:
            o_s_axi_rdata[5:0] <= {interval_enable_reg, 1'b0, interval_divider_select_reg};
          `IDX_IRQ_REQUEST_SECOND: o_s_axi_rdata[1] <= dog_interval_irq_flag_reg;
          `IDX_IRQ_ENABLE_THIRD:   o_s_axi_rdata[1] <= dog_interval_irq_enable_reg;
          default:                 o_s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dog_timer

// ==== rtl/dog_timer_consts.vh ====
`ifndef DOG_TIMER_CONSTS_VH
`define DOG_TIMER_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define IDX_RESET_CAUSE_STATUS        8'ha1
`define IDX_WATCHDOG_RESET_CONTROL    8'hb6
`define IDX_WATCHDOG_REFRESH_KEY      8'hb7
`define IDX_TIMED_ACCESS_KEY          8'hf7
`define IDX_WATCHDOG_INTERVAL_CONTROL 8'hff
`define IDX_IRQ_REQUEST_SECOND        8'h97
`define IDX_IRQ_ENABLE_THIRD          8'h9a

// reset values
`define RST_RESET_CAUSE_STATUS        8'h00
`define RST_WATCHDOG_RESET_CONTROL    8'h04
`define RST_WATCHDOG_INTERVAL_CONTROL 8'h00
`define RST_RESET_DIVIDER_SELECT      4'h4
`define RST_INTERVAL_DIVIDER_SELECT   4'h0

// field positions
`define BIT_CTRL_ENABLE               5
`define BIT_CAUSE_DOG                 3
`define BIT_CAUSE_SOFTWARE            2
`define BIT_CAUSE_LOW_VOLTAGE         1
`define BIT_CAUSE_POWER_ON            0
`define BIT_DOG_INTERVAL_IRQ          1

// key values
`define KEY_REFRESH_A                 8'h55
`define KEY_REFRESH_B                 8'haa
`define KEY_ACCESS_FIRST              8'h55
`define KEY_ACCESS_SECOND             8'haa
`define KEY_ACCESS_THIRD              8'h5a

// timing: counter length and interval prescale step (oscillator ticks)
`define DOG_COUNT_WRAP                8'hff
`define INTERVAL_STEP_TICKS           16'h0008

// bus answers
`define AXI_RESP_OKAY                 2'b00
`define AXI_RESP_SLVERR               2'b10

`endif

// ==== rtl/dog_tick_counter.v ====
`timescale 1ns/1ps
`include "dog_timer_consts.vh"

module dog_tick_counter (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_reset,
  // control
  input  wire        i_run,
  input  wire        i_clear,
  input  wire        i_osc_tick,
  input  wire [15:0] i_div_len,
  // state
  output reg  [7:0]  o_count,
  output reg         o_wrap
);

  reg  [15:0] prescale_reg;
  wire        step;

  assign step = i_osc_tick && (prescale_reg == i_div_len - 16'h0001);

  always @(posedge i_core_clk) begin
    if (i_reset || i_clear || !i_run) begin
      prescale_reg <= 16'h0000;
      o_count      <= 8'h00;
      o_wrap       <= 1'b0;
    end else begin
      o_wrap <= 1'b0;
      if (i_osc_tick) begin
        if (step) begin
          prescale_reg <= 16'h0000;
          o_count      <= o_count + 8'h01;
          // wrap from 255 back to zero
          if (o_count == `DOG_COUNT_WRAP) begin
            o_wrap <= 1'b1;
          end
        end else begin
          prescale_reg <= prescale_reg + 16'h0001;
        end
      end
    end
  end

endmodule // dog_tick_counter

// ==== tb/dog_timer_chk.sv ====
`timescale 1ns/1ps
`include "dog_timer_consts.vh"

module dog_timer_chk (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  // bus handshakes
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic [1:0]  o_s_axi_rresp,
  // watchdog
  input wire logic        i_irq_vector_entered,
  input wire logic        o_chip_reset_req,
  input wire logic        o_dog_interval_irq,
  input wire logic        o_stop_wakeup
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // 256 ticks need at least 512 cycles, so an earlier overflow is a miscount
  logic [9:0] since_reg;
  always @(posedge i_core_clk) begin
    if (i_reset || o_chip_reset_req) since_reg <= 10'h000;
    else if (since_reg != 10'h3ff) since_reg <= since_reg + 10'h001;
  end

  AST_QUIET_AFTER_RESET: assert property (
    $fell(i_reset) |-> !o_chip_reset_req && !o_s_axi_bvalid && !o_s_axi_rvalid)
    else $error("outputs active right after reset");
  AST_OVF_NOT_EARLY: assert property (
    o_chip_reset_req |-> since_reg >= 10'h1f4) else $error("overflow came too early");
  AST_REQ_ONE_CYCLE: assert property (
    o_chip_reset_req |=> !o_chip_reset_req) else $error("reset request longer than one cycle");
  AST_WAKE_FOLLOWS_IRQ: assert property (
    o_stop_wakeup == o_dog_interval_irq) else $error("wakeup differs from interval irq");
  AST_VECTOR_CLEARS: assert property (
    o_dog_interval_irq && i_irq_vector_entered |=> !o_dog_interval_irq)
    else $error("vector entry did not clear interval flag");
  AST_WRITE_ANSWER: assert property (
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid)
    else $error("write response missing");
  AST_READ_ANSWER: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("read data missing");
  AST_B_DROPS: assert property (
    o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid) else $error("bvalid held after handshake");
  AST_R_DROPS: assert property (
    o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid) else $error("rvalid held after handshake");
  AST_READY_LOW: assert property (
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready) else $error("write ready while answering");

  cover property (o_chip_reset_req);
  cover property ($rose(o_dog_interval_irq));
  cover property (o_s_axi_rvalid && o_s_axi_rresp == `AXI_RESP_SLVERR);
endmodule // dog_timer_chk

bind dog_timer dog_timer_chk u_dog_timer_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rresp(o_s_axi_rresp),
  .i_irq_vector_entered(i_irq_vector_entered), .o_chip_reset_req(o_chip_reset_req),
  .o_dog_interval_irq(o_dog_interval_irq), .o_stop_wakeup(o_stop_wakeup));

// ==== tb/dog_timer_bench.sv ====
`timescale 1ns/1ps
`include "dog_timer_consts.vh"

module dog_timer_bench;
  localparam [7:0] ST = `IDX_RESET_CAUSE_STATUS;
  localparam [7:0] RC = `IDX_WATCHDOG_RESET_CONTROL;
  localparam [7:0] RK = `IDX_WATCHDOG_REFRESH_KEY;
  localparam [7:0] TK = `IDX_TIMED_ACCESS_KEY;
  localparam [7:0] IC = `IDX_WATCHDOG_INTERVAL_CONTROL;
  localparam [7:0] IQ = `IDX_IRQ_REQUEST_SECOND;
  localparam [7:0] IE = `IDX_IRQ_ENABLE_THIRD;
  localparam [1:0] OK = `AXI_RESP_OKAY;
  localparam [1:0] ER = `AXI_RESP_SLVERR;

  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         osc = 1'b0;
  reg  [4:0]  ev  = 5'h00;
  reg         awv = 1'b0;
  reg         wv  = 1'b0;
  reg         bry = 1'b0;
  reg         arv = 1'b0;
  reg         rry = 1'b0;
  reg  [11:0] awa = 12'h000;
  reg  [11:0] ara = 12'h000;
  reg  [31:0] wd  = 32'h0000_0000;
  reg  [3:0]  ws  = 4'h0;
  reg  [7:0]  rb;
  reg  [33:0] re;
  reg  [33:0] exp_r[$];
  reg  [1:0]  exp_b[$];
  integer     err_total = 0;
  integer     n_compared = 0;
  integer     seed = 32'h0000_748b;
  integer     cyc = 0;
  integer     req_cnt = 0;
  integer     irq_cnt = 0;
  integer     t0, d, i, k;
  wire        awr, wr_rdy, bv, arr, rv, req, irq, wake;
  wire [1:0]  br, rr;
  wire [31:0] rd;

  dog_timer u_dog_timer (
    .i_core_clk(clk), .i_reset(rst), .i_internal_rc_oscillator(osc),
    .i_chip_reset(ev[4]), .i_software_reset_event(ev[3]), .i_low_voltage_reset_event(ev[2]),
    .i_power_on_reset_event(ev[1]), .i_irq_vector_entered(ev[0]),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .i_s_axi_arprot(3'h0),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
    .o_chip_reset_req(req), .o_dog_interval_irq(irq), .o_stop_wakeup(wake));

  initial forever #20 clk = ~clk;

  // oscillator tick every second core cycle keeps the timing windows short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc <= ~osc;
    if (req) req_cnt <= req_cnt + 1;
    if (irq) irq_cnt <= irq_cnt + 1;
  end

  task check(input [63:0] nm, input [31:0] seen, input [31:0] expv);
    n_compared = n_compared + 1;
    if (seen !== expv) begin
      err_total = err_total + 1;
      $display("BAD %0s expected %h seen %h", nm, expv, seen);
    end
  endtask

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task hang;
    err_total = err_total + 1;
    $display("BAD wait expected done seen timeout");
    end_of_test;
  endtask

  // an empty queue yields unknowns, so a surplus answer is a mismatch
  always @(posedge clk) begin
    if (bv && bry) check("bresp", br, exp_b.size() ? exp_b.pop_front() : 'x);
    if (rv && rry) begin
      re = exp_r.size() ? exp_r.pop_front() : 'x;
      check("rresp", rr, re[33:32]);
      check("rdata", rd, re[31:0]);
    end
  end

  task wr(input [7:0] idx, input [7:0] v, input [1:0] resp);
    integer n;
    @(posedge clk);
    exp_b.push_back(resp);
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= {2'b00, idx, 2'b00};
    wd  <= {24'h00_0000, v};
    ws  <= 4'h1;
    bry <= 1'b1;
    n = 0;
    while (n < 100) begin
      @(posedge clk);
      n = n + 1;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
      if (bv) n = 1000;
    end
    bry <= 1'b0;
    if (n != 1000) hang;
  endtask

  task rdt(input [7:0] idx, input [7:0] v, input [1:0] resp);
    integer n;
    @(posedge clk);
    exp_r.push_back({resp, 24'h00_0000, v});
    arv <= 1'b1;
    ara <= {2'b00, idx, 2'b00};
    rry <= 1'b1;
    n = 0;
    while (n < 100) begin
      @(posedge clk);
      n = n + 1;
      if (arv && arr) arv <= 1'b0;
      if (rv) n = 1000;
    end
    rry <= 1'b0;
    if (n != 1000) hang;
  endtask

  task pulse(input [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
  endtask

  task unlock;
    wr(TK, `KEY_ACCESS_FIRST, OK);
    wr(TK, `KEY_ACCESS_SECOND, OK);
    wr(TK, `KEY_ACCESS_THIRD, OK);
  endtask

  task wait_on(input bit which, input integer lim);
    integer n;
    n = 0;
    while (n < lim && (which ? irq : req) !== 1'b1) begin
      @(posedge clk);
      n = n + 1;
    end
    if (n >= lim) hang;
  endtask

  task win(input integer e, input integer lo);
    check("elapsed", (cyc - t0 >= e - lo) && (cyc - t0 <= e + 12), 1);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdt(ST, 8'h00, OK);
    rdt(RC, 8'h04, OK);
    rdt(IC, 8'h00, OK);
    rdt(RK, 8'h00, OK);
    rdt(TK, 8'h00, OK);
    rdt(8'h10, 8'h00, ER);
    wr(8'h10, 8'h5a, ER);
    rb = $random(seed);
    rb[7] = 1'b0;
    wr(TK, `KEY_ACCESS_FIRST, OK);
    wr(TK, rb, OK);
    wr(TK, `KEY_ACCESS_THIRD, OK);
    wr(RC, 8'h20, OK);
    rdt(RC, 8'h04, OK);
    for (d = 0; d < 2; d = d + 1) begin
      unlock;
      wr(RC, 8'h20 | d[7:0], OK);
      if (d == 0) begin
        unlock;
        wr(RC, 8'h00, OK);
        rdt(RC, 8'h20, OK);
        k = req_cnt;
        for (i = 0; i < 6; i = i + 1) begin
          repeat (100 + ($random(seed) & 255)) @(posedge clk);
          wr(RK, $random(seed) & 1 ? `KEY_REFRESH_A : `KEY_REFRESH_B, OK);
        end
        check("req", req_cnt, k);
      end
      t0 = cyc;
      wait_on(0, 1500);
      win(512 << d, 8 + (2 << d));
      rdt(RC, 8'h04, OK);
      rdt(ST, 8'h08, OK);
    end
    pulse(5'b01110);
    rdt(ST, 8'h0f, OK);
    pulse(5'b10000);
    rdt(ST, 8'h0f, OK);
    wr(ST, 8'h00, OK);
    rdt(ST, 8'h00, OK);
    wr(IE, 8'h02, OK);
    unlock;
    wr(IC, 8'h21, OK);
    t0 = cyc;
    rdt(IC, 8'h21, OK);
    wait_on(1, 9000);
    check("wake", wake, 1);
    win(8192, 40);
    rdt(IQ, 8'h02, OK);
    pulse(5'b00001);
    // the clear lands on the edge that ends the pulse; look one edge later
    @(posedge clk);
    check("irq", irq, 0);
    check("wake", wake, 0);
    rdt(IQ, 8'h00, OK);
    wr(IE, 8'h00, OK);
    k = irq_cnt;
    repeat (8300) @(posedge clk);
    check("irq", irq_cnt, k);
    rdt(IQ, 8'h02, OK);
    pulse(5'b10000);
    rdt(IC, 8'h00, OK);
    pulse(5'b01000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdt(ST, 8'h00, OK);
    rdt(RC, 8'h04, OK);
    end_of_test;
  end
endmodule // dog_timer_bench
